// ==== verilog/traverse_frequency_pattern.sv ====
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module traverse_frequency_pattern #(
    parameter int TICKS_PER_TENTH = traverse_pkg::TICKS_PER_TENTH_DEF
) (
    input  wire logic                       ref_clk_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       forward_start_cmd_i,
    input  wire logic                       reverse_start_cmd_i,
    input  wire logic                       traverse_enable_input_i,
    input  wire logic                       second_function_select_i,
    input  wire logic                       ext_op_mode_i,
    input  wire logic                       stall_active_i,
    output logic [traverse_pkg::FREQ_W-1:0] freq_cmd_o,
    output logic                            run_reverse_o,
    output logic                            traverse_active_o,
    input  wire logic [7:0]                 s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [7:0]                 s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready
);
    import traverse_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [NPIN-1:0][2:0] sync;
        logic [NPIN-1:0]      pin;
        logic                 awready;
        logic                 wready;
        logic                 aw_full;
        logic                 w_full;
        logic [7:0]           awaddr;
        logic [31:0]          wdata;
        logic [3:0]           wstrb;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 arready;
        logic                 rvalid;
        logic [1:0]           rresp;
        logic [31:0]          rdata;
        logic [1:0]           mode;
        logic                 term_asg;
        logic                 shape;
        logic [FREQ_W-1:0]    fset;
        logic [4:0]           amp;
        logic [5:0]           r2f;
        logic [5:0]           f2r;
        logic [TIME_W-1:0]    trise;
        logic [TIME_W-1:0]    tfall;
        logic [TIME_W-1:0]    nacc;
        logic [TIME_W-1:0]    ndec;
        logic [TIME_W-1:0]    sacc;
        logic [TIME_W-1:0]    sdec;
        logic [FREQ_W-1:0]    fmax;
        logic [FREQ_W-1:0]    fmin;
        logic [FREQ_W-1:0]    sh_f0;
        logic [4:0]           sh_amp;
        logic [5:0]           sh_r2f;
        logic [5:0]           sh_f2r;
        logic [TIME_W-1:0]    sh_trise;
        logic [TIME_W-1:0]    sh_tfall;
        run_state_t           st;
        logic [PF_W-1:0]      freq;
        logic [ACC_W-1:0]     acc;
        logic                 en_prev;
        logic                 rev;
        logic [FREQ_W-1:0]    out;
        logic                 active;
    } state_t;

    localparam state_t RST_S = '{
        mode: MODE_RST, amp: AMP_RST, r2f: COMP_RST, f2r: COMP_RST,
        trise: TIME_RST, tfall: TIME_RST, nacc: TIME_RST, ndec: TIME_RST,
        sacc: TIME_RST, sdec: TIME_RST, fmax: FMAX_RST, fmin: FMIN_RST,
        sh_amp: AMP_RST, sh_r2f: COMP_RST, sh_f2r: COMP_RST,
        sh_trise: TIME_RST, sh_tfall: TIME_RST, st: ST_IDLE,
        default: '0};

    state_t q;
    state_t d;

    ////////////////////////////////////////////////////////////////////////
    // Byte-lane merge for partial writes
    function automatic logic [31:0] merge(input logic [31:0] o,
                                          input logic [31:0] w,
                                          input logic [3:0]  s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[b*8 +: 8] = w[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Time fields never drop below one tenth of a second
    function automatic logic [TIME_W-1:0] tlim(input logic [TIME_W-1:0] t);
        return (t < TIME_MIN) ? TIME_MIN : ((t > TIME_MAX) ? TIME_MAX : t);
    endfunction

    // Ramp time in ticks
    function automatic logic [ACC_W-1:0] ticks(input logic [TIME_W-1:0] t);
        return ACC_W'(t) * ACC_W'(TICKS_PER_TENTH);
    endfunction

    // Register word as software sees it; shared by reads and merged writes
    function automatic logic [31:0] cur_word(input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0;
        case (a)
            CTRL_OFS:   r = 32'({q.shape, q.term_asg, q.mode});
            FSET_OFS:   r = 32'(q.fset);
            AMP_OFS:    r = 32'(q.amp);
            COMP_OFS:   r = {18'h0, q.f2r, 2'h0, q.r2f};
            TRVT_OFS:   r = {q.tfall, q.trise};
            NORMT_OFS:  r = {q.ndec, q.nacc};
            SECT_OFS:   r = {q.sdec, q.sacc};
            LIMIT_OFS:  r = {q.fmin, q.fmax};
            STATUS_OFS: begin
                r[FREQ_W-1:0] = q.out;
                r[ST_LSB +: 3] = q.st;
                r[DIR_BIT] = q.rev;
                r[ACT_BIT] = q.active;
            end
            default: begin
                r = 32'h0;
            end
        endcase
        return r;
    endfunction

    // Raw pin vector, indexed by the synchroniser loop
    logic [NPIN-1:0] pin_raw;
    logic [31:0]     wm;
    assign pin_raw = {second_function_select_i, traverse_enable_input_i,
                      reverse_start_cmd_i, forward_start_cmd_i};

    ////////////////////////////////////////////////////////////////////////
    // Pattern geometry from the latched settings
    logic [FREQ_W-1:0] f1;
    logic [FREQ_W-1:0] f2;
    logic [FREQ_W-1:0] f3;
    logic [PF_W-1:0]   top;
    logic [PF_W-1:0]   bot;
    logic              pending;
    logic              start;
    logic              en;
    logic              trav_ok;

    always_comb begin
        f1  = FREQ_W'((32'(q.sh_f0) * 32'(q.sh_amp)) / PCT_DIV);
        f2  = FREQ_W'((32'(f1) * 32'(q.sh_r2f)) / PCT_DIV);
        f3  = FREQ_W'((32'(f1) * 32'(q.sh_f2r)) / PCT_DIV);
        top = PF_W'(q.sh_f0) + PF_W'(f1);
        bot = PF_W'(q.sh_f0) - PF_W'(f1);
        pending = (q.fset != q.sh_f0) || (q.amp != q.sh_amp)
                || (q.r2f != q.sh_r2f) || (q.f2r != q.sh_f2r)
                || (q.trise != q.sh_trise) || (q.tfall != q.sh_tfall);
        start = q.pin[0] | q.pin[1];
        en = q.term_asg ? q.pin[2] : 1'b1;
        trav_ok = en && ((q.mode == MODE_ANY)
                || (q.mode == MODE_EXT && ext_op_mode_i));
    end

    ////////////////////////////////////////////////////////////////////////
    // Ramp selection and stepping
    logic [PF_W-1:0]   tgt;
    logic [PF_W-1:0]   span;
    logic [TIME_W-1:0] tm;
    logic [ACC_W-1:0]  nacc_sum;
    logic              step;
    logic              up;

    always_comb begin
        up = 1'b0;
        tgt = q.freq;
        span = PF_W'(q.fmax);
        tm = TIME_MIN;
        case (q.st)
            ST_TO_F0: begin
                tgt = PF_W'(q.sh_f0);
            end
            ST_UP: begin
                tgt = top;
                span = PF_W'({f1, 1'b0});
                tm = q.sh_trise;
            end
            ST_DOWN: begin
                tgt = bot;
                span = PF_W'({f1, 1'b0});
                tm = q.sh_tfall;
            end
            ST_STOP: begin
                tgt = '0;
            end
            default: begin
                tgt = q.freq;
            end
        endcase
        up = q.freq < tgt;
        if (q.st == ST_TO_F0 || q.st == ST_STOP) begin
            if (q.pin[3]) begin
                tm = up ? q.sacc : q.sdec;
            end else begin
                tm = up ? q.nacc : q.ndec;
            end
            // S-curve eases in near the target; traverse never does
            if (q.shape && ((up ? tgt - q.freq : q.freq - tgt)
                    < PF_W'(q.fmax >> 3))) begin
                span = span >> 1;
            end
        end
        // One unit step when the span accumulator passes the ramp ticks
        nacc_sum = q.acc + ACC_W'(span);
        step = (nacc_sum >= ticks(tm)) && (q.freq != tgt);
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        d = q;
        wm = 32'h0;
        // Three-stage pin synchroniser, change taken when stages 2 and 3 agree
        for (int i = 0; i < NPIN; i++) begin
            d.sync[i] = {q.sync[i][1:0], pin_raw[i]};
            if (q.sync[i][1] == q.sync[i][2]) begin
                d.pin[i] = q.sync[i][2];
            end
        end

        // Write address and data taken in either order
        if (q.awready && s_axi_awvalid) begin
            d.aw_full = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (q.wready && s_axi_wvalid) begin
            d.w_full = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (d.aw_full && d.w_full && !q.bvalid) begin
            d.aw_full = 1'b0;
            d.w_full = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = RESP_OKAY;
            wm = merge(cur_word(d.awaddr), d.wdata, d.wstrb);
            case (d.awaddr)
                CTRL_OFS: begin
                    d.mode = wm[MODE_LSB +: 2];
                    d.term_asg = wm[TERM_BIT];
                    d.shape = wm[SHAPE_BIT];
                end
                FSET_OFS: begin
                    d.fset = wm[FREQ_W-1:0];
                end
                AMP_OFS: begin
                    d.amp = wm[4:0];
                    if (d.amp > AMP_MAX) begin
                        d.amp = AMP_MAX;
                    end
                end
                COMP_OFS: begin
                    d.r2f = wm[5:0];
                    d.f2r = wm[F2R_LSB +: 6];
                    if (d.r2f > COMP_MAX) begin
                        d.r2f = COMP_MAX;
                    end
                    if (d.f2r > COMP_MAX) begin
                        d.f2r = COMP_MAX;
                    end
                end
                TRVT_OFS: begin
                    d.trise = tlim(wm[TIME_W-1:0]);
                    d.tfall = tlim(wm[HI_LSB +: TIME_W]);
                end
                NORMT_OFS: begin
                    d.nacc = tlim(wm[TIME_W-1:0]);
                    d.ndec = tlim(wm[HI_LSB +: TIME_W]);
                end
                SECT_OFS: begin
                    d.sacc = tlim(wm[TIME_W-1:0]);
                    d.sdec = tlim(wm[HI_LSB +: TIME_W]);
                end
                LIMIT_OFS: begin
                    d.fmax = wm[FREQ_W-1:0];
                    d.fmin = wm[HI_LSB +: FREQ_W];
                end
                STATUS_OFS: begin
                    d.bresp = RESP_OKAY;
                end
                default: begin
                    d.bresp = RESP_SLVERR;
                end
            endcase
        end
        // Readies fall while a write waits for its response
        d.awready = !d.aw_full && !d.bvalid;
        d.wready = !d.w_full && !d.bvalid;

        // Reads answer one cycle after the address is taken
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (q.arready && s_axi_arvalid) begin
            d.rvalid = 1'b1;
            d.rresp = RESP_OKAY;
            d.rdata = cur_word(s_axi_araddr);
            // Unmapped offsets read zero with an error response
            if ((s_axi_araddr > STATUS_OFS) || (s_axi_araddr[1:0] != 2'h0)) begin
                d.rresp = RESP_SLVERR;
            end
        end
        d.arready = !d.rvalid;

        // Frequency stepping; the accumulator keeps the remainder
        d.en_prev = en;
        if (step) begin
            d.freq = up ? q.freq + PF_W'(1) : q.freq - PF_W'(1);
            d.acc = nacc_sum - ticks(tm);
        end else if (q.freq != tgt) begin
            d.acc = nacc_sum;
        end

        // Run sequence
        case (q.st)
            ST_IDLE: begin
                d.freq = '0;
                d.acc = '0;
                d.sh_f0 = q.fset;
                d.sh_amp = q.amp;
                d.sh_r2f = q.r2f;
                d.sh_f2r = q.f2r;
                d.sh_trise = q.trise;
                d.sh_tfall = q.tfall;
                if (start) begin
                    d.rev = q.pin[1] && !q.pin[0];
                    d.st = ST_TO_F0;
                end
            end
            ST_TO_F0: begin
                if (!start) begin
                    d.st = ST_STOP;
                end else if (q.freq == PF_W'(q.sh_f0)) begin
                    d.acc = '0;
                    if (pending) begin
                        // Old f0 reached; move on to the new one
                        d.sh_f0 = q.fset;
                        d.sh_amp = q.amp;
                        d.sh_r2f = q.r2f;
                        d.sh_f2r = q.f2r;
                        d.sh_trise = q.trise;
                        d.sh_tfall = q.tfall;
                    end else if (trav_ok && !stall_active_i) begin
                        d.st = ST_UP;
                    end
                end
            end
            ST_UP, ST_DOWN: begin
                if (!start) begin
                    d.st = ST_STOP;
                    d.acc = '0;
                end else if (stall_active_i) begin
                    d.st = ST_STALL;
                end else if (en != q.en_prev || !trav_ok || pending) begin
                    d.st = ST_TO_F0;
                    d.acc = '0;
                end else if (q.st == ST_UP && q.freq == top) begin
                    d.freq = top - PF_W'(f2);
                    d.acc = '0;
                    d.st = ST_DOWN;
                end else if (q.st == ST_DOWN && q.freq == bot) begin
                    d.freq = bot + PF_W'(f3);
                    d.acc = '0;
                    d.st = ST_UP;
                end
            end
            ST_STALL: begin
                // Drive holds its own frequency while stall prevention acts
                d.acc = '0;
                if (!start) begin
                    d.st = ST_STOP;
                end else if (!stall_active_i) begin
                    d.st = ST_TO_F0;
                end
            end
            ST_STOP: begin
                if (start) begin
                    d.st = ST_TO_F0;
                    d.acc = '0;
                end else if (q.freq == '0) begin
                    d.st = ST_IDLE;
                end
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase

        // Output clamp; a stopping ramp may pass below the minimum
        if (d.st == ST_IDLE || d.st == ST_STOP) begin
            d.out = (d.freq > PF_W'(q.fmax)) ? q.fmax : FREQ_W'(d.freq);
        end else if (d.freq > PF_W'(q.fmax)) begin
            d.out = q.fmax;
        end else if (d.freq < PF_W'(q.fmin)) begin
            d.out = q.fmin;
        end else begin
            d.out = FREQ_W'(d.freq);
        end
        d.active = (d.st == ST_UP) || (d.st == ST_DOWN);
    end

    ////////////////////////////////////////////////////////////////////////
    // Single state register
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            q <= RST_S;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign freq_cmd_o        = q.out;
    assign run_reverse_o     = q.rev;
    assign traverse_active_o = q.active;
    assign s_axi_awready     = q.awready;
    assign s_axi_wready      = q.wready;
    assign s_axi_bvalid      = q.bvalid;
    assign s_axi_bresp       = q.bresp;
    assign s_axi_arready     = q.arready;
    assign s_axi_rvalid      = q.rvalid;
    assign s_axi_rresp       = q.rresp;
    assign s_axi_rdata       = q.rdata;
endmodule
`default_nettype wire

// ==== verilog/traverse_pkg.sv ====
`default_nettype none
package traverse_pkg;
    // Widths
    localparam int FREQ_W = 16;
    localparam int PF_W   = FREQ_W + 1;
    localparam int TIME_W = 16;
    localparam int ACC_W  = 42;
    localparam int ADDR_W = 8;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] FSET_OFS   = 8'h04;
    localparam logic [7:0] AMP_OFS    = 8'h08;
    localparam logic [7:0] COMP_OFS   = 8'h0c;
    localparam logic [7:0] TRVT_OFS   = 8'h10;
    localparam logic [7:0] NORMT_OFS  = 8'h14;
    localparam logic [7:0] SECT_OFS   = 8'h18;
    localparam logic [7:0] LIMIT_OFS  = 8'h1c;
    localparam logic [7:0] STATUS_OFS = 8'h20;
    // Field positions
    localparam int MODE_LSB  = 0;
    localparam int TERM_BIT  = 2;
    localparam int SHAPE_BIT = 3;
    localparam int F2R_LSB   = 8;
    localparam int HI_LSB    = 16;
    localparam int ST_LSB    = 16;
    localparam int DIR_BIT   = 19;
    localparam int ACT_BIT   = 20;
    // Reset values and ranges
    localparam logic [1:0]        MODE_RST = 2'h0;
    localparam logic [4:0]        AMP_RST  = 5'h0a;
    localparam logic [4:0]        AMP_MAX  = 5'h19;
    localparam logic [5:0]        COMP_RST = 6'h0a;
    localparam logic [5:0]        COMP_MAX = 6'h32;
    localparam logic [TIME_W-1:0] TIME_RST = 16'h0032;
    localparam logic [TIME_W-1:0] TIME_MIN = 16'h0001;
    localparam logic [TIME_W-1:0] TIME_MAX = 16'h8ca0;
    localparam logic [FREQ_W-1:0] FMAX_RST = 16'h1770;
    localparam logic [FREQ_W-1:0] FMIN_RST = 16'h0000;
    localparam int                PCT_DIV  = 100;
    // Timing: times count in tenths of a second
    localparam longint TENTH_S_NS = 100000000;
    localparam longint CLK_NS     = 4;
    localparam int TICKS_PER_TENTH_DEF = int'(TENTH_S_NS / CLK_NS);
    // Mode codes
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_EXT = 2'h1;
    localparam logic [1:0] MODE_ANY = 2'h2;
    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Pin vector layout
    localparam int NPIN = 4;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_TO_F0 = 3'b001,
        ST_UP    = 3'b010,
        ST_DOWN  = 3'b011,
        ST_STALL = 3'b100,
        ST_STOP  = 3'b101
    } run_state_t;
endpackage
`default_nettype wire

// ==== verif/traverse_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module traverse_asserts (
    input wire logic                              ref_clk_i,
    input wire logic                              rst_n_i,
    input wire logic                              forward_start_cmd_i,
    input wire logic                              reverse_start_cmd_i,
    input wire logic                              stall_active_i,
    input wire logic [traverse_pkg::FREQ_W-1:0]   freq_cmd_o,
    input wire logic                              traverse_active_o,
    input wire logic                              s_axi_awready,
    input wire logic                              s_axi_wready,
    input wire logic                              s_axi_bvalid,
    input wire logic                              s_axi_bready,
    input wire logic                              s_axi_arvalid,
    input wire logic                              s_axi_arready,
    input wire logic                              s_axi_rvalid,
    input wire logic                              s_axi_rready
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Start low long enough to pass the pin synchroniser
    sequence start_gone_s;
        (!forward_start_cmd_i && !reverse_start_cmd_i) [*7];
    endsequence
    stop_idle_a: assert property (start_gone_s |-> !traverse_active_o)
        else $error("traverse still active after start withdrawn");
    stall_hold_a: assert property (stall_active_i [*3] |-> $stable(freq_cmd_o))
        else $error("frequency moved during stall");
    step_one_a: assert property (!traverse_active_o && $past(traverse_active_o) == 1'b0 |->
        {1'b0, freq_cmd_o} <= {1'b0, $past(freq_cmd_o)} + 17'h1 &&
        {1'b0, freq_cmd_o} + 17'h1 >= {1'b0, $past(freq_cmd_o)}) else $error("normal ramp step above one");
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read data dropped early");
    wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
endmodule
bind traverse_frequency_pattern traverse_asserts u_chk (.*);
`default_nettype wire

// ==== verif/drive_stage_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module drive_stage_model (
    input  wire logic                            ref_clk_i,
    input  wire logic [traverse_pkg::FREQ_W-1:0] freq_cmd_i,
    input  wire logic                            overload_i,
    output logic                                 stall_o
);
    // Current limit only trips while the motor is turning
    always_ff @(posedge ref_clk_i) begin
        stall_o <= overload_i && (freq_cmd_i != '0);
    end
endmodule
`default_nettype wire

// ==== verif/traverse_frequency_pattern_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module traverse_frequency_pattern_test;
    import traverse_pkg::*;
    localparam int F0 = 100;
    localparam int F1 = F0 * AMP_RST / PCT_DIV;
    logic ref_clk_i = 0, rst_n_i = 0, forward_start_cmd_i = 0, reverse_start_cmd_i = 0, ovl = 0;
    logic traverse_enable_input_i = 0, second_function_select_i = 0, ext_op_mode_i = 0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, run_reverse_o, traverse_active_o;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [FREQ_W-1:0] freq_cmd_o, hi, lo;
    wire logic stall_active_i;
    int error_cnt = 0, n_tests = 0;
    traverse_frequency_pattern #(.TICKS_PER_TENTH(1)) dut (.*);
    drive_stage_model u_drv (.ref_clk_i(ref_clk_i), .freq_cmd_i(freq_cmd_o), .overload_i(ovl), .stall_o(stall_active_i));
    ////////////////////////////////////////////////////////////////////////
    // Shared compare, bus and wait helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
        forever begin
            @(posedge ref_clk_i);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 0;
        chk(s_axi_bresp, RESP_OKAY);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        @(posedge ref_clk_i);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        forever begin
            @(posedge ref_clk_i);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 0;
        chk(s_axi_rdata, e);
        chk(s_axi_rresp, r);
    endtask
    // Bounded wait; the caller compares afterwards so a miss is reported
    task automatic wait_for(input bit act, input logic [FREQ_W-1:0] f);
        for (int i = 0; i < 3000 && !(act ? traverse_active_o === 1'b1 : freq_cmd_o === f); i++) @(posedge ref_clk_i);
    endtask
    task automatic sweep();
        hi = '0; lo = '1;
        repeat (100) begin
            @(posedge ref_clk_i);
            if (freq_cmd_o > hi) hi = freq_cmd_o;
            if (freq_cmd_o < lo) lo = freq_cmd_o;
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial forever #2 ref_clk_i = ~ref_clk_i;
    // Whole run is under a thousand cycles
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        error_cnt++;
        final_report();
    end
    initial begin
        repeat (4) @(posedge ref_clk_i);
        rst_n_i <= 1;
        rd(AMP_OFS, 32'(AMP_RST), RESP_OKAY);
        rd(COMP_OFS, 32'h0a0a, RESP_OKAY);
        rd(TRVT_OFS, {TIME_RST, TIME_RST}, RESP_OKAY);
        rd(8'h40, 32'h0, RESP_SLVERR);
        wr(FSET_OFS, F0);
        wr(TRVT_OFS, 32'h0);
        wr(NORMT_OFS, 32'h0);
        wr(LIMIT_OFS, 32'd105);
        forward_start_cmd_i <= 1;
        wait_for(0, F0);
        chk(freq_cmd_o, F0);
        repeat (20) @(posedge ref_clk_i);
        chk(traverse_active_o, 0);
        wr(CTRL_OFS, 32'(MODE_EXT));
        repeat (20) @(posedge ref_clk_i);
        chk(traverse_active_o, 0);
        ext_op_mode_i <= 1;
        wait_for(1, '0);
        chk(traverse_active_o, 1);
        sweep();
        chk(hi, 105);
        chk(lo, F0 - F1);
        ovl <= 1;
        repeat (6) @(posedge ref_clk_i);
        chk(traverse_active_o, 0);
        ovl <= 0;
        wait_for(1, '0);
        chk(traverse_active_o, 1);
        wr(CTRL_OFS, 32'(MODE_ANY) | (32'h1 << TERM_BIT));
        repeat (10) @(posedge ref_clk_i);
        chk(traverse_active_o, 0);
        traverse_enable_input_i <= 1;
        wait_for(1, '0);
        chk(traverse_active_o, 1);
        forward_start_cmd_i <= 0;
        wait_for(0, '0);
        chk(freq_cmd_o, 0);
        wr(SECT_OFS, 32'h00c800c8);
        second_function_select_i <= 1; reverse_start_cmd_i <= 1;
        repeat (60) @(posedge ref_clk_i);
        chk(32'(freq_cmd_o < 16'h002d), 1);
        wait_for(0, F0);
        chk(freq_cmd_o, F0);
        chk(run_reverse_o, 1);
        final_report();
    end
endmodule
`default_nettype wire
